// ==== include/csbd_map.svh ====
// Opcode, field and clock-count constants for the condition byte and table store decoder.
`ifndef CSBD_MAP_SVH
`define CSBD_MAP_SVH

// Escape byte that opens every two-byte opcode of this group.
`define CSBD_ESC 8'h0F
// Second opcode bytes.
`define CSBD_OP_LOCAL_GRP 8'h00
`define CSBD_OP_TABLE_GRP 8'h01
`define CSBD_OP_SETCC_HI 4'h9
`define CSBD_OP_NO_OVERFLOW 8'h91
`define CSBD_OP_NOT_BELOW 8'h93
`define CSBD_OP_NOT_EQUAL 8'h95
`define CSBD_OP_ABOVE 8'h97
`define CSBD_OP_OVERFLOW 8'h90
`define CSBD_OP_NEGATIVE 8'h98
`define CSBD_OP_POSITIVE 8'h99
`define CSBD_OP_PARITY_EVEN 8'h9A
`define CSBD_OP_PARITY_ODD 8'h9B
`define CSBD_OP_GREATER_EQUAL 8'h9D
`define CSBD_OP_GREATER 8'h9F

// ModR/M fields.
`define CSBD_MOD_HI 7
`define CSBD_MOD_LO 6
`define CSBD_REG_HI 5
`define CSBD_REG_LO 3
`define CSBD_RM_HI 2
`define CSBD_RM_LO 0
`define CSBD_MOD_REGISTER 2'h3
`define CSBD_REG_SETCC 3'h0
`define CSBD_REG_GLOBAL 3'h0
`define CSBD_REG_INTERRUPT 3'h1
`define CSBD_REG_LOCAL 3'h0

// Clock counts on a cache hit.
`define CSBD_CLK_SETCC 3'h1
`define CSBD_CLK_TABLE 3'h6
`define CSBD_CLK_LOCAL 3'h1

// Stored values and operand sizes in bytes.
`define CSBD_BYTE_TRUE 8'h01
`define CSBD_BYTE_FALSE 8'h00
`define CSBD_SIZE_BYTE 3'h1
`define CSBD_SIZE_WORD 3'h2
`define CSBD_SIZE_TABLE 3'h6

`endif

// ==== include/csbd_pkg.sv ====
// Types shared by the condition byte and table store decoder.
package csbd_pkg;

	typedef enum logic [0:0] {
		CSBD_IDLE,
		CSBD_RUN
	} csbd_state_t;

	typedef enum logic [2:0] {
		CSBD_K_NONE,
		CSBD_K_SETCC,
		CSBD_K_GLOBAL,
		CSBD_K_INTERRUPT,
		CSBD_K_LOCAL
	} csbd_kind_t;

	typedef struct packed {
		csbd_state_t st;
		logic [2:0] cnt;
		logic busy;
		logic done;
		logic illegal;
		logic reg_we;
		logic mem_we;
		logic flags_we;
		logic pend_mem;
		logic [2:0] rm;
		logic [2:0] bytes;
		logic [47:0] data;
	} csbd_regs_t;

endpackage : csbd_pkg

// ==== hdl/csbd_cond_eval.sv ====
// Flag condition evaluator for the condition byte store opcodes.
`timescale 1ns/1ps
`default_nettype none
module csbd_cond_eval (
	input wire logic [3:0] i_cc,
	input wire logic i_cf,
	input wire logic i_zf,
	input wire logic i_sf,
	input wire logic i_of,
	input wire logic i_pf,
	output logic o_true
);

	// Bits 3..1 pick a base test and bit 0 inverts it, so one table serves all sixteen codes.
	function automatic logic csbd_base(input logic [2:0] sel, input logic cf, input logic zf,
		input logic sf, input logic of, input logic pf);
		case (sel)
			3'h0: csbd_base = of;
			3'h1: csbd_base = cf;
			3'h2: csbd_base = zf;
			3'h3: csbd_base = cf | zf;
			3'h4: csbd_base = sf;
			3'h5: csbd_base = pf;
			3'h6: csbd_base = sf ^ of;
			default: csbd_base = zf | (sf ^ of);
		endcase
	endfunction : csbd_base

	// The result only reads flags; nothing here can write them.
	always_comb begin
		o_true = csbd_base(i_cc[3:1], i_cf, i_zf, i_sf, i_of, i_pf) ^ i_cc[0];
	end

endmodule : csbd_cond_eval
`default_nettype wire

// ==== hdl/csbd_decode.sv ====
// Decode and execute unit for condition byte stores and descriptor table register stores.
`timescale 1ns/1ps
`default_nettype none
`include "csbd_map.svh"
module csbd_decode
	import csbd_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_issue,
	input wire logic [7:0] i_opcode1,
	input wire logic [7:0] i_opcode2,
	input wire logic [7:0] i_modrm,
	input wire logic i_prot_mode,
	input wire logic i_flag_cf,
	input wire logic i_flag_zf,
	input wire logic i_flag_sf,
	input wire logic i_flag_of,
	input wire logic i_flag_pf,
	input wire logic [31:0] i_gdt_base,
	input wire logic [15:0] i_gdt_limit,
	input wire logic [31:0] i_idt_base,
	input wire logic [15:0] i_idt_limit,
	input wire logic [15:0] i_ldt_sel,
	output logic o_busy,
	output logic o_done,
	output logic o_illegal,
	output logic o_reg_we,
	output logic o_mem_we,
	output logic o_flags_we,
	output logic [2:0] o_rm,
	output logic [2:0] o_wr_bytes,
	output logic [47:0] o_wr_data
);

	localparam csbd_regs_t CSBD_RESET = '{
		st: CSBD_IDLE,
		cnt: 3'h0,
		busy: 1'b0,
		done: 1'b0,
		illegal: 1'b0,
		reg_we: 1'b0,
		mem_we: 1'b0,
		flags_we: 1'b0,
		pend_mem: 1'b0,
		rm: 3'h0,
		bytes: 3'h0,
		data: 48'h0
	};

	csbd_regs_t s_q;
	csbd_regs_t s_d;
	logic cond_true;
	logic accept;
	csbd_kind_t kind;
	logic [1:0] mod_f;
	logic [2:0] reg_f;
	logic [2:0] rm_f;

	// Classifies an opcode pair and ModR/M reg field; unlisted encodings give none.
	function automatic csbd_kind_t csbd_classify(input logic [7:0] op1, input logic [7:0] op2,
		input logic [2:0] regf);
		csbd_classify = CSBD_K_NONE;
		if (op1 == `CSBD_ESC) begin
			if (op2[7:4] == `CSBD_OP_SETCC_HI && regf == `CSBD_REG_SETCC) begin
				csbd_classify = CSBD_K_SETCC;
			end else if (op2 == `CSBD_OP_TABLE_GRP && regf == `CSBD_REG_GLOBAL) begin
				csbd_classify = CSBD_K_GLOBAL;
			end else if (op2 == `CSBD_OP_TABLE_GRP && regf == `CSBD_REG_INTERRUPT) begin
				csbd_classify = CSBD_K_INTERRUPT;
			end else if (op2 == `CSBD_OP_LOCAL_GRP && regf == `CSBD_REG_LOCAL) begin
				csbd_classify = CSBD_K_LOCAL;
			end
		end
	endfunction : csbd_classify

	// ModR/M field split.
	assign mod_f = i_modrm[`CSBD_MOD_HI:`CSBD_MOD_LO];
	assign reg_f = i_modrm[`CSBD_REG_HI:`CSBD_REG_LO];
	assign rm_f = i_modrm[`CSBD_RM_HI:`CSBD_RM_LO];
	assign kind = csbd_classify(i_opcode1, i_opcode2, reg_f);
	// A request is only taken while idle; issues during a table store are ignored.
	assign accept = i_issue && (s_q.st == CSBD_IDLE);

	csbd_cond_eval u_cond (
		.i_cc(i_opcode2[3:0]),
		.i_cf(i_flag_cf),
		.i_zf(i_flag_zf),
		.i_sf(i_flag_sf),
		.i_of(i_flag_of),
		.i_pf(i_flag_pf),
		.o_true(cond_true)
	);

	// Next state: single-clock stores finish on the accepting edge, table stores count down.
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.illegal = 1'b0;
		s_d.reg_we = 1'b0;
		s_d.mem_we = 1'b0;
		// The flag file is never written by this group.
		s_d.flags_we = 1'b0;
		case (s_q.st)
			CSBD_IDLE: begin
				if (accept) begin
					s_d.rm = rm_f;
					s_d.pend_mem = (mod_f != `CSBD_MOD_REGISTER);
					case (kind)
						CSBD_K_SETCC: begin
							// Every condition code shares the one evaluator.
							s_d.data = {40'h0, cond_true ? `CSBD_BYTE_TRUE : `CSBD_BYTE_FALSE};
							s_d.bytes = `CSBD_SIZE_BYTE;
							s_d.done = 1'b1;
							s_d.reg_we = (mod_f == `CSBD_MOD_REGISTER);
							s_d.mem_we = (mod_f != `CSBD_MOD_REGISTER);
						end
						CSBD_K_GLOBAL: begin
							// Image is captured at issue so a late table reload cannot tear it.
							s_d.data = {i_gdt_base, i_gdt_limit};
							s_d.bytes = `CSBD_SIZE_TABLE;
							s_d.cnt = `CSBD_CLK_TABLE - 3'h1;
							s_d.st = CSBD_RUN;
						end
						CSBD_K_INTERRUPT: begin
							s_d.data = {i_idt_base, i_idt_limit};
							s_d.bytes = `CSBD_SIZE_TABLE;
							s_d.cnt = `CSBD_CLK_TABLE - 3'h1;
							s_d.st = CSBD_RUN;
						end
						CSBD_K_LOCAL: begin
							// There is no real-mode form, so real mode reports it as illegal.
							if (i_prot_mode) begin
								s_d.data = {32'h0, i_ldt_sel};
								s_d.bytes = `CSBD_SIZE_WORD;
								s_d.done = 1'b1;
								s_d.reg_we = (mod_f == `CSBD_MOD_REGISTER);
								s_d.mem_we = (mod_f != `CSBD_MOD_REGISTER);
							end else begin
								s_d.illegal = 1'b1;
							end
						end
						default: begin
							s_d.illegal = 1'b1;
						end
					endcase
				end
			end
			CSBD_RUN: begin
				if (s_q.cnt == 3'h1) begin
					s_d.done = 1'b1;
					s_d.reg_we = !s_q.pend_mem;
					s_d.mem_we = s_q.pend_mem;
					s_d.st = CSBD_IDLE;
				end else begin
					s_d.cnt = s_q.cnt - 3'h1;
				end
			end
			default: begin
				s_d = CSBD_RESET;
			end
		endcase
		s_d.busy = (s_d.st == CSBD_RUN);
	end

	// Synchronous reset; all outputs below come straight from this register.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			s_q <= CSBD_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_busy = s_q.busy;
	assign o_done = s_q.done;
	assign o_illegal = s_q.illegal;
	assign o_reg_we = s_q.reg_we;
	assign o_mem_we = s_q.mem_we;
	assign o_flags_we = s_q.flags_we;
	assign o_rm = s_q.rm;
	assign o_wr_bytes = s_q.bytes;
	assign o_wr_data = s_q.data;

	// Helper terms read only by the checks below.
	logic setcc_acc;
	assign setcc_acc = accept && kind == CSBD_K_SETCC;

	// Each condition byte opcode stores its documented flag test one clock later.
	chk_not_below_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_NOT_BELOW |=> o_done && !o_flags_we
		&& o_wr_data[7:0] == {7'h0, !$past(i_flag_cf)})
		else $error("not-below byte wrong or late");
	chk_above_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_ABOVE |=> o_done
		&& o_wr_data[7:0] == {7'h0, !($past(i_flag_cf) || $past(i_flag_zf))})
		else $error("above byte wrong or late");
	chk_not_equal_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_NOT_EQUAL |=> o_done
		&& o_wr_data[7:0] == {7'h0, !$past(i_flag_zf)})
		else $error("not-equal byte wrong or late");
	chk_ge_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_GREATER_EQUAL |=> o_done
		&& o_wr_data[0] == ($past(i_flag_sf) == $past(i_flag_of)))
		else $error("greater-equal byte wrong or late");
	chk_greater_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_GREATER |=> o_done
		&& o_wr_data[0] == (!$past(i_flag_zf) && $past(i_flag_sf) == $past(i_flag_of)))
		else $error("greater byte wrong or late");
	chk_no_ovf_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_NO_OVERFLOW |=> o_done
		&& o_wr_data[0] == !$past(i_flag_of))
		else $error("no-overflow byte wrong or late");
	chk_parity_odd: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_PARITY_ODD |=> o_done
		&& o_wr_data[0] == !$past(i_flag_pf))
		else $error("parity-odd byte wrong or late");
	chk_positive_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_POSITIVE |=> o_done
		&& o_wr_data[0] == !$past(i_flag_sf))
		else $error("sign-clear byte wrong or late");
	chk_overflow_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_OVERFLOW |=> o_done
		&& o_wr_data[0] == $past(i_flag_of))
		else $error("overflow byte wrong or late");
	chk_parity_even: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_PARITY_EVEN |=> o_done
		&& o_wr_data[0] == $past(i_flag_pf))
		else $error("parity-even byte wrong or late");
	chk_negative_byte: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc && i_opcode2 == `CSBD_OP_NEGATIVE |=> o_done
		&& o_wr_data[0] == $past(i_flag_sf))
		else $error("sign-set byte wrong or late");
	// Table stores stay silent for five clocks and write on the sixth.
	chk_global_six: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		accept && kind == CSBD_K_GLOBAL |=> (o_busy && !o_done) [*5] ##1
		(o_done && o_wr_bytes == `CSBD_SIZE_TABLE
		&& o_wr_data == {$past(i_gdt_base, 6), $past(i_gdt_limit, 6)}))
		else $error("global table store not in six clocks");
	chk_interrupt_six: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		accept && kind == CSBD_K_INTERRUPT |=> !o_done [*5] ##1
		(o_done && (o_reg_we || o_mem_we)
		&& o_wr_data == {$past(i_idt_base, 6), $past(i_idt_limit, 6)}))
		else $error("interrupt table store not in six clocks");
	chk_local_mode: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		accept && kind == CSBD_K_LOCAL |=> (o_done && o_wr_data[15:0] == $past(i_ldt_sel))
		!= (o_illegal && !$past(i_prot_mode)))
		else $error("local selector store mode handling wrong");
	chk_dest_select: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc |=> o_mem_we == ($past(mod_f) != `CSBD_MOD_REGISTER) && o_reg_we == !o_mem_we
		&& o_wr_data[7:1] == 7'h0 && o_rm == $past(rm_f))
		else $error("condition byte destination wrong");
	// A condition store always writes one byte whose upper bits are clear.
	chk_byte_size: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		setcc_acc |=> o_wr_bytes == `CSBD_SIZE_BYTE && o_wr_data[47:8] == 40'h0)
		else $error("condition byte size or upper bits wrong");
	chk_local_write: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		accept && kind == CSBD_K_LOCAL && i_prot_mode |=> o_wr_bytes == `CSBD_SIZE_WORD
		&& o_reg_we == ($past(mod_f) == `CSBD_MOD_REGISTER) && o_mem_we == !o_reg_we)
		else $error("local selector write size or target wrong");
	// A refused request must never reach the register file or memory.
	chk_refused_quiet: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_illegal |-> !o_done && !o_reg_we && !o_mem_we)
		else $error("refused request produced a write");
	chk_table_start: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		accept && (kind == CSBD_K_GLOBAL || kind == CSBD_K_INTERRUPT) |=> o_busy
		&& o_rm == $past(rm_f) && o_wr_bytes == `CSBD_SIZE_TABLE)
		else $error("table store did not start correctly");

endmodule : csbd_decode
`default_nettype wire

// ==== verification/condition_byte_set_decode_bench.sv ====
// Self-checking bench for the condition byte and table store decoder.
`timescale 1ns/1ps
`default_nettype none
module condition_byte_set_decode_bench;
	logic clk, rst, issue, prot;
	logic [7:0] op1, op2, modrm;
	logic [4:0] fl;
	logic [31:0] gbase, ibase;
	logic [15:0] glim, ilim, lsel;
	logic busy, done, ill, rwe, mwe, fwe;
	logic [2:0] rm, wbytes;
	logic [47:0] wdata, e;
	logic [7:0] m;
	int fails, n_checks, cyc, r, f, k;
	// Each row: second opcode byte, then 32 expected result bits, bit f for flag pattern f = {cf,zf,sf,of,pf}.
	logic [39:0] rows [11] = '{40'h930000FFFF, 40'h97000000FF, 40'h9500FF00FF, 40'h9DC3C3C3C3,
		40'h9F00C300C3, 40'h9133333333, 40'h9B55555555, 40'h990F0F0F0F, 40'h90CCCCCCCC,
		40'h9AAAAAAAAA, 40'h98F0F0F0F0};
	logic [23:0] bad [5] = '{24'h0E93C0, 24'h0F93C8, 24'h0F0110, 24'h0F0008, 24'h0F97F8};

	csbd_decode u_csbd_decode (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_issue(issue), .i_opcode1(op1), .i_opcode2(op2),
		.i_modrm(modrm), .i_prot_mode(prot), .i_flag_cf(fl[4]), .i_flag_zf(fl[3]),
		.i_flag_sf(fl[2]), .i_flag_of(fl[1]), .i_flag_pf(fl[0]), .i_gdt_base(gbase),
		.i_gdt_limit(glim), .i_idt_base(ibase), .i_idt_limit(ilim), .i_ldt_sel(lsel),
		.o_busy(busy), .o_done(done), .o_illegal(ill), .o_reg_we(rwe), .o_mem_we(mwe),
		.o_flags_we(fwe), .o_rm(rm), .o_wr_bytes(wbytes), .o_wr_data(wdata)
	);

	task automatic chk_bit(input string nm, input logic x, input logic g);
		n_checks++;
		if (g !== x) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", nm, x, g);
		end
	endtask : chk_bit

	task automatic chk_vec(input string nm, input logic [47:0] x, input logic [47:0] g);
		n_checks++;
		if (g !== x) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk_vec

	// Presents one request for a single cycle and returns just after the taking edge.
	task automatic send(input logic [7:0] a, input logic [7:0] b, input logic [7:0] mr,
		input logic [4:0] v);
		@(posedge clk);
		op1 <= a;
		op2 <= b;
		modrm <= mr;
		fl <= v;
		issue <= 1'b1;
		@(posedge clk);
		issue <= 1'b0;
		#1;
	endtask : send

	// The flag write enable must stay low whatever the outcome.
	task automatic expect_out(input logic d, input logic i, input logic rw, input logic mw);
		chk_bit("done", d, done);
		chk_bit("illegal", i, ill);
		chk_bit("reg_we", rw, rwe);
		chk_bit("mem_we", mw, mwe);
		chk_bit("flags_we", 1'b0, fwe);
	endtask : expect_out

	// Runs a table store, with an ignored request and a changed image during the busy time.
	task automatic table_store(input logic [7:0] mr);
		send(8'h0F, 8'h01, mr, 5'h1F);
		chk_vec("table_data", e, wdata);
		chk_vec("table_bytes", 48'h6, {45'h0, wbytes});
		chk_vec("table_rm", {45'h0, mr[2:0]}, {45'h0, rm});
		for (k = 1; k < 6; k++) begin
			chk_bit("busy", 1'b1, busy);
			chk_bit("done_early", 1'b0, done);
			@(posedge clk);
			if (k == 1) begin
				issue <= 1'b1;
				op2 <= 8'h93;
				// Both images flip, so an image read at completion instead of issue shows up.
				gbase <= ~gbase;
				ibase <= ~ibase;
			end
			if (k == 2) begin
				issue <= 1'b0;
			end
			#1;
		end
		chk_bit("busy_end", 1'b0, busy);
		expect_out(1'b1, 1'b0, mr[7:6] == 2'h3, mr[7:6] != 2'h3);
		chk_vec("table_hold", e, wdata);
		@(posedge clk);
		#1;
		chk_bit("done_drop", 1'b0, done);
	endtask : table_store

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	// Core clock at 20 MHz.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// The whole run needs under a thousand cycles, so a hang is cut off at 2000 cycles, twice that figure.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			end_of_test();
		end
	end

	// Main sequence: reset, table of condition stores, then the hand-written cases.
	initial begin
		rst = 1'b1;
		issue = 1'b0;
		prot = 1'b1;
		op1 = 8'h0F;
		op2 = 8'h00;
		modrm = 8'h00;
		fl = 5'h00;
		gbase = 32'h89ABCDEF;
		glim = 16'h03FF;
		ibase = 32'h00102000;
		ilim = 16'h07FF;
		lsel = 16'h0048;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		expect_out(1'b0, 1'b0, 1'b0, 1'b0);
		chk_vec("reset_data", 48'h0, wdata);
		for (r = 0; r < 11; r++) begin
			for (f = 0; f < 32; f++) begin
				m = f[0] ? 8'hC5 : 8'h06;
				send(8'h0F, rows[r][39:32], m, f[4:0]);
				expect_out(1'b1, 1'b0, f[0], !f[0]);
				chk_vec("cond_byte", {47'h0, rows[r][f]}, wdata);
				chk_vec("cond_bytes", 48'h1, {45'h0, wbytes});
				chk_vec("cond_rm", {45'h0, m[2:0]}, {45'h0, rm});
			end
		end
		@(posedge clk);
		#1;
		chk_bit("done_one_cycle", 1'b0, done);
		e = {gbase, glim};
		table_store(8'h07);
		e = {ibase, ilim};
		table_store(8'hCA);
		send(8'h0F, 8'h00, 8'hC3, 5'h00);
		expect_out(1'b1, 1'b0, 1'b1, 1'b0);
		chk_vec("sel_data", {32'h0, lsel}, wdata);
		chk_vec("sel_bytes", 48'h2, {45'h0, wbytes});
		@(posedge clk);
		prot <= 1'b0;
		send(8'h0F, 8'h00, 8'h06, 5'h00);
		expect_out(1'b0, 1'b1, 1'b0, 1'b0);
		for (r = 0; r < 5; r++) begin
			send(bad[r][23:16], bad[r][15:8], bad[r][7:0], 5'h00);
			expect_out(1'b0, 1'b1, 1'b0, 1'b0);
		end
		// A reset in the middle of a table store must abandon it cleanly.
		send(8'h0F, 8'h01, 8'h00, 5'h00);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		chk_bit("busy_after_reset", 1'b0, busy);
		chk_vec("data_after_reset", 48'h0, wdata);
		@(posedge clk);
		rst <= 1'b0;
		send(8'h0F, 8'h95, 8'hC1, 5'h00);
		expect_out(1'b1, 1'b0, 1'b1, 1'b0);
		chk_vec("byte_after_reset", 48'h1, wdata);
		end_of_test();
	end
endmodule : condition_byte_set_decode_bench
`default_nettype wire
